// [design/wrs_supervisor.sv]
// Watchdog, reset output, square-wave and power-fail supervisor logic
//
// Strobed register access was left to the implementer.
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
module wrs_supervisor
    import wrs_pkg::*;
#(
    parameter int unsigned RecLongCycles = REC_LONG_CYC,
    parameter int unsigned RecShortCycles = REC_SHORT_CYC,
    parameter int unsigned FiltCycles = RSTIN_FILT_CYC
)
(
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic regWr,
    input wire logic regRd,
    output logic [7:0] regRdData,
    input wire logic wdKickIn,
    input wire logic resetInFall,
    input wire logic resetInRise,
    input wire logic supplyOk,
    input wire logic pwrfailInA,
    input wire logic pwrfailInB,
    output logic rstOut,
    output logic rstOe,
    output logic irqOut,
    output logic irqOe,
    output logic sqwOut,
    output logic sqwOe,
    output logic clk32kOut,
    output logic clk32kOe,
    output logic pwrfailOutAN,
    output logic pwrfailOutBN
);

    ////////////////////////////////////////////////////////////////////////////
    // Input synchronisers; only the second stage is read by logic
    logic [5:0] syncA_reg;
    logic [5:0] syncB_reg;
    logic kickPrev_reg;
    logic [5:0] pinRaw;

    assign pinRaw = {pwrfailInB, pwrfailInA, supplyOk, resetInRise,
                     resetInFall, wdKickIn};

    always_ff @(posedge sys_clk)
    begin
        if (!rstn)
        begin
            // Idle pin levels, so no false edge or supply loss after reset
            syncA_reg <= 6'h0a;
            syncB_reg <= 6'h0a;
            kickPrev_reg <= 1'b0;
        end
        else
        begin
            syncA_reg <= pinRaw;
            syncB_reg <= syncA_reg;
            kickPrev_reg <= syncB_reg[0];
        end
    end

    logic kickEdge;
    logic supOk;
    assign kickEdge = syncB_reg[0] ^ kickPrev_reg;
    assign supOk = syncB_reg[3];

    ////////////////////////////////////////////////////////////////////////////
    // Reset-input deglitch: a level must hold FiltCycles before it is seen
    logic [1:0] filt_reg;
    logic [1:0] filtPrev_reg;
    logic [7:0] filtCnt_reg [2];

    always_ff @(posedge sys_clk)
    begin
        if (!rstn)
        begin
            filt_reg <= 2'h1;
            filtPrev_reg <= 2'h1;
            filtCnt_reg[0] <= 8'h00;
            filtCnt_reg[1] <= 8'h00;
        end
        else
        begin
            filtPrev_reg <= filt_reg;
            for (int i = 0; i < 2; i++)
            begin
                if (syncB_reg[i + 1] == filt_reg[i])
                    filtCnt_reg[i] <= 8'h00;
                else if (filtCnt_reg[i] >= 8'(FiltCycles - 1))
                begin
                    filt_reg[i] <= syncB_reg[i + 1];
                    filtCnt_reg[i] <= 8'h00;
                end
                else
                    filtCnt_reg[i] <= filtCnt_reg[i] + 8'h01;
            end
        end
    end

    logic rstInFallEv;
    logic rstInRiseEv;
    logic rstInHold;
    assign rstInFallEv = filtPrev_reg[0] & ~filt_reg[0];
    assign rstInRiseEv = ~filtPrev_reg[1] & filt_reg[1];
    assign rstInHold = ~filt_reg[0] | filt_reg[1];

    ////////////////////////////////////////////////////////////////////////////
    // Oscillator time base: fractional divider gives an exact average rate
    logic [26:0] acc_reg;
    logic oscTick;
    logic [15:0] presc_reg;

    assign oscTick = (acc_reg + TICK_INC) >= TICK_WRAP;

    always_ff @(posedge sys_clk)
    begin
        if (!rstn)
        begin
            acc_reg <= 27'h0000000;
            presc_reg <= 16'h0000;
        end
        else
        begin
            if (oscTick)
            begin
                acc_reg <= acc_reg + TICK_INC - TICK_WRAP;
                presc_reg <= presc_reg + 16'h0001;
            end
            else
                acc_reg <= acc_reg + TICK_INC;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Registers
    logic [7:0] wdCtl_reg;
    logic [7:0] almSqw_reg;
    logic [7:0] sqwSel_reg;
    logic [7:0] cfg_reg;
    logic wdFlag_reg;
    logic wdIrq_reg;
    logic wdHalt_reg;
    logic wdTimeout;
    logic wdRstMode;
    logic porEvent;
    logic wdWrite;

    assign wdWrite = regWr && (regAddr == WD_CTL_ADDR);
    assign wdRstMode = wdCtl_reg[WD_STEER_BIT];
    // Supply loss and reset inputs clear the watchdog control and only the masked alarm and config bits
    assign porEvent = ~supOk | rstInFallEv | rstInRiseEv;

    always_ff @(posedge sys_clk)
    begin
        if (!rstn)
        begin
            wdCtl_reg <= WD_CTL_RST;
            almSqw_reg <= ALM_SQW_RST;
            sqwSel_reg <= SQW_SEL_RST;
            cfg_reg <= CFG_RST;
        end
        else if (porEvent)
        begin
            wdCtl_reg <= WD_CTL_RST;
            almSqw_reg <= almSqw_reg & ~ALM_POR_CLR;
            cfg_reg <= cfg_reg & ~CFG_POR_CLR;
        end
        else if (wdTimeout && wdRstMode)
        begin
            // Timeout clear outranks a write to another register in the same cycle; a watchdog control write blocks the timeout
            wdCtl_reg <= WD_CTL_RST;
            almSqw_reg <= almSqw_reg & ~ALM_WD_CLR;
            cfg_reg <= cfg_reg & ~CFG_WD_CLR;
        end
        else if (regWr)
        begin
            if (regAddr == WD_CTL_ADDR)
                wdCtl_reg <= regWrData;
            if (regAddr == ALM_SQW_ADDR)
                almSqw_reg <= regWrData;
            if (regAddr == SQW_SEL_ADDR)
                sqwSel_reg <= regWrData;
            if (regAddr == CFG_ADDR)
                cfg_reg <= regWrData;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Watchdog counter
    logic [4:0] wdMult;
    logic [1:0] wdRes;
    logic [18:0] wdSub_reg;
    logic [4:0] wdCnt_reg;
    logic [18:0] stepLast;
    logic wdRun;
    logic wdRestart;

    assign wdMult = wdCtl_reg[WD_MULT_LSB +: 5];
    assign wdRes = wdCtl_reg[WD_RES_LSB +: 2];
    // Step length 4096 ticks scaled by four per resolution code
    assign stepLast = 19'(RES0_TICKS << (2 * wdRes)) - 19'h00001;
    assign wdRun = (wdMult != 5'h00) && !wdHalt_reg;
    assign wdRestart = kickEdge | wdWrite;
    // Counting from zero at the restart keeps error under one step
    assign wdTimeout = wdRun && !wdRestart && oscTick
                       && (wdSub_reg == stepLast)
                       && (wdCnt_reg == wdMult - 5'h01);

    always_ff @(posedge sys_clk)
    begin
        if (!rstn || porEvent || wdRestart || !wdRun || wdTimeout)
        begin
            wdSub_reg <= 19'h00000;
            wdCnt_reg <= 5'h00;
        end
        else if (oscTick)
        begin
            if (wdSub_reg == stepLast)
            begin
                wdSub_reg <= 19'h00000;
                wdCnt_reg <= wdCnt_reg + 5'h01;
            end
            else
                wdSub_reg <= wdSub_reg + 19'h00001;
        end
    end

    // Interrupt-mode timeout halts the watchdog until software rewrites it
    always_ff @(posedge sys_clk)
    begin
        if (!rstn || porEvent)
        begin
            wdIrq_reg <= 1'b0;
            wdHalt_reg <= 1'b0;
        end
        else if (wdTimeout && !wdRstMode)
        begin
            wdIrq_reg <= 1'b1;
            wdHalt_reg <= 1'b1;
        end
        else
        begin
            if (kickEdge || (wdWrite && regWrData == 8'h00))
                wdIrq_reg <= 1'b0;
            if (wdWrite)
                wdHalt_reg <= 1'b0;
        end
    end

    // Flag: a timeout in the clearing read's cycle wins
    always_ff @(posedge sys_clk)
    begin
        if (!rstn)
            wdFlag_reg <= 1'b0;
        else if (wdTimeout)
            wdFlag_reg <= 1'b1;
        else if (regRd && regAddr == FLAGS_ADDR)
            wdFlag_reg <= 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Recovery timer behind the reset output and power-fail outputs
    logic [23:0] recCnt_reg;
    logic supRec_reg;
    logic resetHold;
    logic [23:0] recLoad;

    assign resetHold = ~supOk | rstInHold;
    assign recLoad = cfg_reg[CFG_TR_BIT] ? 24'(RecShortCycles)
                                         : 24'(RecLongCycles);

    always_ff @(posedge sys_clk)
    begin
        if (!rstn)
        begin
            recCnt_reg <= 24'(RecLongCycles);
            supRec_reg <= 1'b1;
        end
        else
        begin
            if (resetHold || (wdTimeout && wdRstMode))
                recCnt_reg <= recLoad;
            else if (recCnt_reg != 24'h000000)
                recCnt_reg <= recCnt_reg - 24'h000001;
            if (!supOk)
                supRec_reg <= 1'b1;
            else if (recCnt_reg == 24'h000000)
                supRec_reg <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pin drivers; all registered
    logic [3:0] sqwCode;
    logic sqwWave;
    logic sqwDrive;
    logic oscRun;

    assign sqwCode = sqwSel_reg[SQW_SEL_LSB +: 4];
    // Code 1 is bit 0; code n above 1 is bit n, halving each step
    assign sqwWave = (sqwCode == 4'h1) ? presc_reg[0]
                                       : presc_reg[sqwCode];
    assign oscRun = ~cfg_reg[CFG_ST_BIT];

    always_comb
    begin
        if (almSqw_reg[SQW_EN_BIT] && sqwCode != 4'h0)
            sqwDrive = 1'b1;
        else
            // Frequency test only while the square wave enable is clear
            sqwDrive = !almSqw_reg[SQW_EN_BIT] && cfg_reg[CFG_FT_BIT]
                       && oscRun;
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rstn)
        begin
            rstOut <= 1'b0;
            rstOe <= 1'b1;
            irqOut <= 1'b0;
            irqOe <= 1'b0;
            sqwOut <= 1'b0;
            sqwOe <= 1'b0;
            clk32kOut <= 1'b0;
            clk32kOe <= 1'b0;
            pwrfailOutAN <= 1'b0;
            pwrfailOutBN <= 1'b0;
        end
        else
        begin
            rstOe <= resetHold || recCnt_reg != 24'h000000;
            irqOe <= wdIrq_reg;
            if (!sqwDrive)
            begin
                sqwOut <= 1'b0;
                sqwOe <= 1'b0;
            end
            else if (cfg_reg[CFG_SQW_OPEN_DRAIN_SEL_BIT])
            begin
                sqwOut <= 1'b0;
                sqwOe <= almSqw_reg[SQW_EN_BIT] ? ~sqwWave
                                                : ~presc_reg[FT_TAP];
            end
            else
            begin
                sqwOut <= almSqw_reg[SQW_EN_BIT] ? sqwWave
                                                 : presc_reg[FT_TAP];
                sqwOe <= 1'b1;
            end
            clk32kOe <= cfg_reg[CFG_32K_EN_BIT] && oscRun
                        && ~presc_reg[0];
            if (!supOk)
            begin
                pwrfailOutAN <= 1'b0;
                pwrfailOutBN <= 1'b0;
            end
            else if (supRec_reg)
            begin
                pwrfailOutAN <= 1'b1;
                pwrfailOutBN <= 1'b1;
            end
            else
            begin
                pwrfailOutAN <= ~syncB_reg[4];
                pwrfailOutBN <= ~syncB_reg[5];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read port: data one cycle after the strobe, zero elsewhere
    always_ff @(posedge sys_clk)
    begin
        if (!rstn)
            regRdData <= 8'h00;
        else if (regRd)
        begin
            unique case (regAddr)
                WD_CTL_ADDR: regRdData <= wdCtl_reg;
                ALM_SQW_ADDR: regRdData <= almSqw_reg;
                FLAGS_ADDR: regRdData <= {wdFlag_reg, 7'h00};
                SQW_SEL_ADDR: regRdData <= sqwSel_reg;
                CFG_ADDR: regRdData <= cfg_reg;
                STAT_ADDR: regRdData <= {4'h0, wdHalt_reg, wdIrq_reg,
                                         supRec_reg, rstOe};
                default: regRdData <= 8'h00;
            endcase
        end
        else
            regRdData <= 8'h00;
    end

endmodule : wrs_supervisor
`default_nettype wire

// [pkg/wrs_pkg.sv]
// Constants shared by the watchdog, reset and square-wave supervisor
package wrs_pkg;

    // Time base
    localparam int unsigned CLK_HZ = 100_000_000;
    localparam int unsigned OSC_HZ = 32_768;
    localparam int unsigned TICK_HZ = 2 * OSC_HZ;
    localparam logic [26:0] TICK_INC = 27'(TICK_HZ);
    localparam logic [26:0] TICK_WRAP = 27'(CLK_HZ);

    // Register offsets
    localparam logic [7:0] WD_CTL_ADDR = 8'h09;
    localparam logic [7:0] ALM_SQW_ADDR = 8'h0a;
    localparam logic [7:0] FLAGS_ADDR = 8'h0f;
    localparam logic [7:0] SQW_SEL_ADDR = 8'h13;
    localparam logic [7:0] CFG_ADDR = 8'h20;
    localparam logic [7:0] STAT_ADDR = 8'h21;

    // Field positions
    localparam int WD_STEER_BIT = 7;
    localparam int WD_MULT_LSB = 2;
    localparam int WD_RES_LSB = 0;
    localparam int ALM_IRQ_EN_BIT = 7;
    localparam int SQW_EN_BIT = 6;
    localparam int ALM_BKP_EN_BIT = 5;
    localparam int FLAG_WD_BIT = 7;
    localparam int SQW_SEL_LSB = 4;
    localparam int CFG_FT_BIT = 0;
    localparam int CFG_ST_BIT = 1;
    localparam int CFG_OSC_FAIL_IRQ_EN_BIT = 2;
    localparam int CFG_TR_BIT = 3;
    localparam int CFG_32K_EN_BIT = 4;
    localparam int CFG_SQW_OPEN_DRAIN_SEL_BIT = 5;
    localparam int CFG_TAMPER1_IRQ_EN_BIT = 6;
    localparam int CFG_TAMPER2_IRQ_EN_BIT = 7;

    // Reset values
    localparam logic [7:0] WD_CTL_RST = 8'h00;
    localparam logic [7:0] ALM_SQW_RST = 8'h00;
    localparam logic [7:0] SQW_SEL_RST = 8'h00;
    localparam logic [7:0] CFG_RST = 8'h30;

    // Mask of bits cleared by a power-cycle style reset
    localparam logic [7:0] ALM_POR_CLR = 8'he0;
    localparam logic [7:0] CFG_POR_CLR = 8'hc5;
    // Mask of bits cleared by a reset-steered watchdog timeout
    localparam logic [7:0] ALM_WD_CLR = 8'he0;
    localparam logic [7:0] CFG_WD_CLR = 8'h01;

    // Watchdog: 1/16 s in oscillator half-period ticks
    localparam int unsigned RES0_TICKS = TICK_HZ / 16;

    // Recovery time and reset-input filter
    localparam int unsigned REC_LONG_US = 97_000;
    localparam int unsigned REC_SHORT_US = 100;
    localparam int unsigned RSTIN_MIN_NS = 150;
    localparam int unsigned REC_LONG_CYC = REC_LONG_US * (CLK_HZ / 1_000_000);
    localparam int unsigned REC_SHORT_CYC = REC_SHORT_US * (CLK_HZ / 1_000_000);
    localparam int unsigned RSTIN_FILT_CYC =
        (RSTIN_MIN_NS * (CLK_HZ / 1_000_000) + 999) / 1000;

    // Square wave: prescaler bit giving 512 Hz for the frequency test
    localparam int FT_TAP = 6;

endpackage : wrs_pkg

// [bench/wrs_supervisor_properties.sv]
// Port-level assertions for the supervisor, bound onto the design
`timescale 1ns/1ps
`default_nettype none
module wrs_supervisor_properties
    import wrs_pkg::*;
#(
    parameter int unsigned RecShortCycles = REC_SHORT_CYC
)
(
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic regWr,
    input wire logic regRd,
    input wire logic [7:0] regRdData,
    input wire logic resetInFall,
    input wire logic resetInRise,
    input wire logic supplyOk,
    input wire logic pwrfailInA,
    input wire logic pwrfailInB,
    input wire logic rstOut,
    input wire logic rstOe,
    input wire logic irqOut,
    input wire logic irqOe,
    input wire logic sqwOut,
    input wire logic sqwOe,
    input wire logic clk32kOut,
    input wire logic pwrfailOutAN,
    input wire logic pwrfailOutBN
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rstn);

    ////////////////////////////////////////////////////////////////////////
    int lowCnt_reg;
    int quietCnt_reg;
    int upCnt_reg;

    always_ff @(posedge sys_clk)
    begin
        if (!rstn || resetInFall)
            lowCnt_reg <= 0;
        else if (lowCnt_reg < 28)
            lowCnt_reg <= lowCnt_reg + 1;
    end

    // Counts from the last moment a reset input or supply loss was active
    always_ff @(posedge sys_clk)
    begin
        if (!rstn || !resetInFall || resetInRise || !supplyOk)
            quietCnt_reg <= 0;
        else if (quietCnt_reg < 65535)
            quietCnt_reg <= quietCnt_reg + 1;
    end

    // Shortest timeout is 1/16 s, just beyond this 60 ms window
    always_ff @(posedge sys_clk)
    begin
        if (!rstn)
            upCnt_reg <= 0;
        else if (upCnt_reg < 6_000_000)
            upCnt_reg <= upCnt_reg + 1;
    end

    ////////////////////////////////////////////////////////////////////////
    sequence s_wd_write;
        regWr && regAddr == WD_CTL_ADDR;
    endsequence
    sequence s_wd_read;
        regRd && regAddr == WD_CTL_ADDR;
    endsequence

    a_wd_readback: assert property (
        s_wd_write ##1 s_wd_read |=> regRdData == $past(regWrData, 2))
        else $error("watchdog control readback wrong");
    a_irq_quiet: assert property (
        upCnt_reg < 6_000_000 |-> !irqOe)
        else $error("interrupt before any timeout possible");
    a_pf_backup_low: assert property (
        (!supplyOk)[*5] |-> !pwrfailOutAN && !pwrfailOutBN)
        else $error("power-fail outputs high in backup");
    a_rst_on_supply: assert property (
        (!supplyOk)[*5] |-> rstOe)
        else $error("reset not asserted in backup");
    a_rst_on_input: assert property (
        lowCnt_reg == 28 |-> rstOe)
        else $error("reset not asserted for held input");
    a_rst_release_min: assert property (
        $fell(rstOe) |-> quietCnt_reg >= RecShortCycles)
        else $error("reset released before recovery time");
    a_pf_forced_high: assert property (
        $rose(supplyOk) |-> ##6 (pwrfailOutAN && pwrfailOutBN)[*8])
        else $error("power-fail outputs not forced high");
    a_pf_follow: assert property (
        (supplyOk && !rstOe && $stable({pwrfailInA, pwrfailInB}))[*8]
        |-> pwrfailOutAN == !pwrfailInA && pwrfailOutBN == !pwrfailInB)
        else $error("power-fail outputs do not follow comparators");
    a_sqw_drive_form: assert property (
        sqwOut |-> sqwOe)
        else $error("square wave data driven without enable");
    a_pin_data_low: assert property (
        !(rstOut || irqOut || clk32kOut))
        else $error("open-drain pin data not low");
endmodule : wrs_supervisor_properties

bind wrs_supervisor wrs_supervisor_properties #(
    .RecShortCycles(RecShortCycles)
) u_props (.*);
`default_nettype wire

// [bench/wrs_host_model.sv]
// Host processor model on the far side of the supervisor pins
`timescale 1ns/1ps
`default_nettype none
module wrs_host_model
(
    input wire logic sys_clk,
    input wire logic kickReq,
    input wire logic rstOe,
    input wire logic irqOe,
    input wire logic sqwOut,
    input wire logic sqwOe,
    input wire logic clk32kOe,
    output logic wdKickIn,
    output logic rstPinN,
    output logic irqPinN,
    output logic sqwPin,
    output logic clk32kPin
);
    // Open-drain pins rest high through their pull-ups
    assign rstPinN = !rstOe;
    assign irqPinN = !irqOe;
    assign sqwPin = sqwOe ? sqwOut : 1'b1;
    assign clk32kPin = !clk32kOe;

    // Host held in reset cannot kick; either edge counts
    initial wdKickIn = 1'b0;
    always @(posedge sys_clk)
    begin
        if (kickReq && rstPinN)
            wdKickIn <= !wdKickIn;
    end
endmodule : wrs_host_model
`default_nettype wire

// [bench/testbench.sv]
// Self-checking bench for the supervisor
`timescale 1ns/1ps
`default_nettype none
module testbench
    import wrs_pkg::*;
;
    localparam int RecLong = 200;
    localparam int RecShort = 50;
    logic sys_clk, rstn, regWr, regRd, wdKickIn, kickReq;
    logic [7:0] regAddr, regWrData, regRdData;
    logic resetInFall, resetInRise, supplyOk, pwrfailInA, pwrfailInB;
    logic rstOut, rstOe, irqOut, irqOe, sqwOut, sqwOe, clk32kOut, clk32kOe;
    logic pwrfailOutAN, pwrfailOutBN, rstPinN, irqPinN, sqwPin, clk32kPin;
    int mismatches = 0;
    int cmpCount = 0;
    int cycles = 0;

    // Shortened recovery counts keep the run brief
    wrs_supervisor #(.RecLongCycles(RecLong), .RecShortCycles(RecShort),
        .FiltCycles(15)) u_dut (.*);
    wrs_host_model u_host (.*);

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        sys_clk = 1'b0;
        forever #5 sys_clk = !sys_clk;
    end

    always @(posedge sys_clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 100_000)
        begin
            mismatches++;
            final_report();
        end
    end

    task automatic final_report();
        if (mismatches == 0 && cmpCount > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : final_report

    task automatic chk(input string what, input logic [15:0] seen,
        input logic [15:0] exp);
        cmpCount++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : cyc

    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        regAddr <= a;
        regWrData <= d;
        regWr <= 1'b1;
        cyc(1);
        regWr <= 1'b0;
    endtask : reg_wr

    task automatic reg_chk(input logic [7:0] a, input logic [7:0] e);
        regAddr <= a;
        regRd <= 1'b1;
        cyc(1);
        regRd <= 1'b0;
        chk("register read", regRdData, e);
    endtask : reg_chk

    task automatic rec_len(output int n);
        n = 0;
        while (rstOe !== 1'b0 && n < 3000)
        begin
            cyc(1);
            n++;
        end
    endtask : rec_len

    // Counts cycles between two rising pin edges; 0 if the pin is still
    task automatic period(input int w, input int lim, output int p);
        int n;
        int r;
        logic prev;
        p = 0;
        r = 0;
        n = 0;
        prev = w == 0 ? sqwPin : clk32kPin;
        while (r < 2 && n < lim)
        begin
            cyc(1);
            n++;
            if (!prev && (w == 0 ? sqwPin : clk32kPin) === 1'b1)
            begin
                r++;
                if (r == 1)
                    n = 0;
            end
            prev = w == 0 ? sqwPin : clk32kPin;
        end
        if (r == 2)
            p = n;
    endtask : period

    task automatic pulse(input int w, input int len, output logic seen);
        if (w == 0)
            resetInFall <= 1'b0;
        else
            resetInRise <= 1'b1;
        cyc(len);
        seen = rstOe;
        resetInFall <= 1'b1;
        resetInRise <= 1'b0;
    endtask : pulse

    ////////////////////////////////////////////////////////////////////////
    task automatic t_defaults();
        int n;
        chk("reset out at release", rstOe, 1);
        rec_len(n);
        chk("power-up recovery", n inside {[RecLong:RecLong + 10]}, 1);
        reg_chk(WD_CTL_ADDR, 8'h00);
        reg_chk(ALM_SQW_ADDR, 8'h00);
        reg_chk(CFG_ADDR, 8'h30);
        reg_chk(FLAGS_ADDR, 8'h00);
        reg_chk(8'h30, 8'h00);
    endtask : t_defaults

    task automatic t_regs();
        for (int r = 0; r < 4; r++)
        begin
            reg_wr(WD_CTL_ADDR, 8'h04 | 8'(r));
            reg_chk(WD_CTL_ADDR, 8'h04 | 8'(r));
        end
        reg_wr(WD_CTL_ADDR, 8'h8e);
        reg_chk(WD_CTL_ADDR, 8'h8e);
        kickReq <= 1'b1;
        cyc(1);
        kickReq <= 1'b0;
        cyc(20);
        chk("irq after kick", irqOe, 0);
        reg_wr(8'h30, 8'haa);
        reg_chk(8'h30, 8'h00);
        reg_wr(SQW_SEL_ADDR, 8'hf5);
        reg_chk(SQW_SEL_ADDR, 8'hf5);
        reg_wr(WD_CTL_ADDR, 8'h00);
    endtask : t_regs

    task automatic t_rst_in();
        int n;
        logic s;
        reg_wr(WD_CTL_ADDR, 8'h8e);
        reg_wr(ALM_SQW_ADDR, 8'hff);
        reg_wr(CFG_ADDR, 8'hff);
        for (int w = 0; w < 2; w++)
        begin
            pulse(w, 10, s);
            cyc(25);
            chk("short input pulse", rstOe, 0);
            pulse(w, 30, s);
            chk("held reset input", s, 1);
            rec_len(n);
            chk("input recovery", n inside {[RecShort:RecShort + 24]}, 1);
        end
        reg_chk(WD_CTL_ADDR, 8'h00);
        reg_chk(ALM_SQW_ADDR, 8'h1f);
        reg_chk(CFG_ADDR, 8'h3a);
        reg_wr(CFG_ADDR, 8'h30);
    endtask : t_rst_in

    task automatic t_power();
        int n;
        reg_wr(WD_CTL_ADDR, 8'h05);
        pwrfailInA <= 1'b1;
        supplyOk <= 1'b0;
        cyc(10);
        chk("power-fail in backup", {pwrfailOutAN, pwrfailOutBN}, 0);
        chk("reset in backup", rstOe, 1);
        supplyOk <= 1'b1;
        cyc(10);
        chk("power-fail forced", {pwrfailOutAN, pwrfailOutBN}, 3);
        rec_len(n);
        chk("supply recovery", n inside {[RecLong - 12:RecLong + 8]}, 1);
        cyc(8);
        chk("power-fail follow", {pwrfailOutAN, pwrfailOutBN}, 1);
        reg_chk(WD_CTL_ADDR, 8'h00);
        pwrfailInA <= 1'b0;
        pwrfailInB <= 1'b1;
        cyc(8);
        chk("power-fail follow", {pwrfailOutAN, pwrfailOutBN}, 2);
    endtask : t_power

    task automatic t_sqw();
        int p;
        reg_wr(SQW_SEL_ADDR, 8'h10);
        reg_wr(ALM_SQW_ADDR, 8'h40);
        period(0, 4000, p);
        chk("square period code 1", p inside {[3050:3053]}, 1);
        chk("open-drain data", sqwOut, 0);
        reg_wr(CFG_ADDR, 8'h10);
        reg_wr(SQW_SEL_ADDR, 8'h20);
        period(0, 13000, p);
        chk("square period code 2", p inside {[12205:12209]}, 1);
        chk("push-pull enable", sqwOe, 1);
        reg_wr(SQW_SEL_ADDR, 8'h00);
        period(0, 4000, p);
        chk("square code 0", p, 0);
        reg_wr(SQW_SEL_ADDR, 8'h10);
        reg_wr(ALM_SQW_ADDR, 8'h00);
        period(0, 4000, p);
        chk("square disabled", p, 0);
    endtask : t_sqw

    task automatic t_clk32k();
        int p;
        reg_wr(CFG_ADDR, 8'h10);
        period(1, 4000, p);
        chk("32k period", p inside {[3050:3053]}, 1);
        reg_wr(CFG_ADDR, 8'h12);
        period(1, 4000, p);
        chk("32k with stop bit", p, 0);
        reg_wr(CFG_ADDR, 8'h00);
        period(1, 4000, p);
        chk("32k disabled", p, 0);
    endtask : t_clk32k

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        rstn = 1'b0;
        regAddr = 8'h00;
        regWrData = 8'h00;
        regWr = 1'b0;
        regRd = 1'b0;
        kickReq = 1'b0;
        resetInFall = 1'b1;
        resetInRise = 1'b0;
        supplyOk = 1'b1;
        pwrfailInA = 1'b0;
        pwrfailInB = 1'b0;
        cyc(20);
        rstn <= 1'b1;
        t_defaults();
        t_regs();
        t_rst_in();
        t_power();
        t_sqw();
        t_clk32k();
        final_report();
    end
endmodule : testbench
`default_nettype wire
